// [logic/spi_link_if.sv]
// Serial link between the host controller and the protection table device
interface spi_link_if;
    logic cs_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;

    modport device (input cs_n, input sck, input mosi, output miso, output miso_oe);
    modport host   (output cs_n, output sck, output mosi, input miso, input miso_oe);
endinterface

// [logic/spr_device.sv]
// Device end: command decoder, protection table, timed erase/program cycles
`include "spr_params.svh"
module spr_device
    import spr_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        clk_en_i,
    spi_link_if.device       link,
    input  wire logic        wp_i,
    input  wire logic        prot_enable_i,
    output logic             busy_o,
    output logic [63:0]      table_o,
    output logic [8:0]       blocked_o,
    output logic             refused_o,
    output logic             buf1_we_o,
    output logic [2:0]       buf1_addr_o,
    output logic [7:0]       buf1_data_o
);

    dev_regs_t s;
    dev_regs_t next_s;
    logic      prot_on;
    logic [8:0] blk;

    ////////////////////////////////////////////////////////////////////////////
    // Blocking map per sector part

    assign prot_on = prot_enable_i | wp_i;

    assign blk[0] = prot_on & (s.sector_protect_table[7:6] == `PAIR_SET);
    assign blk[1] = prot_on & (s.sector_protect_table[5:4] == `PAIR_SET);

    genvar g;
    generate
        for (g = 1; g < 8; g++) begin : g_sector
            assign blk[g + 1] = prot_on & (s.sector_protect_table[g * 8 +: 8] == `BYTE_ERASED);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic       cs_active;
        logic       cs_rise;
        logic       sck_rise;
        logic       sck_fall;
        logic [7:0] nb;
        cs_active = 1'b0;
        cs_rise   = 1'b0;
        sck_rise  = 1'b0;
        sck_fall  = 1'b0;
        nb        = 8'h00;

        next_s = s;
        next_s.buf1_we = 1'b0;
        next_s.refused = 1'b0;
        next_s.blocked = blk;
        next_s.cs_sync   = {s.cs_sync[1:0], link.cs_n};
        next_s.sck_sync  = {s.sck_sync[1:0], link.sck};
        next_s.mosi_sync = {s.mosi_sync[0], link.mosi};

        cs_active = ~s.cs_sync[1];
        cs_rise   = s.cs_sync[1] & ~s.cs_sync[2];
        sck_rise  = s.sck_sync[1] & ~s.sck_sync[2];
        sck_fall  = ~s.sck_sync[1] & s.sck_sync[2];

        if (s.cycle != CY_NONE) begin
            if (s.timer == 12'h000) begin
                if (s.cycle == CY_ERASE) begin
                    next_s.sector_protect_table = {8{`BYTE_ERASED}};
                end else begin
                    next_s.sector_protect_table = s.stage;
                end
                next_s.cycle = CY_NONE;
            end else begin
                next_s.timer = s.timer - 12'h001;
            end
        end

        if (!cs_active) begin
            if (cs_rise) begin
                // erase starts on deselect after last opcode bit
                if (s.erase_req && s.bit_cnt == 3'h0) begin
                    if (wp_i || s.cycle != CY_NONE) begin
                        next_s.refused = 1'b1;
                    end else begin
                        next_s.cycle = CY_ERASE;
                        next_s.timer = 12'(`ERASE_CYC - 1);
                    end
                end
                if (s.state == DS_PROG_DATA && s.any_data && s.bit_cnt == 3'h0) begin
                    if (wp_i || s.cycle != CY_NONE) begin
                        next_s.refused = 1'b1;
                    end else begin
                        next_s.cycle = CY_PROGRAM;
                        next_s.timer = 12'(`PROG_CYC - 1);
                    end
                end
            end
            next_s.state     = DS_OPCODE;
            next_s.bit_cnt   = 3'h0;
            next_s.byte_cnt  = 2'h0;
            next_s.seq_ok    = 1'b1;
            next_s.erase_req = 1'b0;
            next_s.any_data  = 1'b0;
            next_s.miso      = 1'b0;
            next_s.miso_oe   = 1'b0;
        end else if (sck_rise) begin
            nb = {s.shreg[6:0], s.mosi_sync[1]};
            next_s.shreg   = nb;
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.bit_cnt == 3'h7) begin
                unique case (s.state)
                    DS_OPCODE: begin
                        next_s.byte_cnt = s.byte_cnt + 2'h1;
                        unique case (s.byte_cnt)
                            2'h0: begin
                                if (nb == `OP_READ) begin
                                    next_s.state    = DS_DUMMY;
                                    next_s.byte_cnt = 2'h0;
                                end else begin
                                    next_s.seq_ok = (nb == `OP_PREFIX0);
                                end
                            end
                            2'h1: next_s.seq_ok = s.seq_ok & (nb == `OP_PREFIX1);
                            2'h2: next_s.seq_ok = s.seq_ok & (nb == `OP_PREFIX2);
                            2'h3: begin
                                next_s.state = DS_IGNORE;
                                if (s.seq_ok && nb == `OP_ERASE) begin
                                    next_s.erase_req = 1'b1;
                                end
                                // fourth byte selects program; ignored while busy, with no refused pulse
                                if (s.seq_ok && nb == `OP_PROGRAM && s.cycle == CY_NONE) begin
                                    next_s.state  = DS_PROG_DATA;
                                    next_s.wr_ptr = 3'h0;
                                end
                            end
                        endcase
                    end
                    DS_PROG_DATA: begin
                        next_s.stage[{s.wr_ptr, 3'b000} +: 8] = nb;
                        next_s.wr_ptr   = s.wr_ptr + 3'h1;
                        next_s.any_data = 1'b1;
                        // working copy lands in buffer 1
                        next_s.buf1_we   = 1'b1;
                        next_s.buf1_addr = s.wr_ptr;
                        next_s.buf1_data = nb;
                    end
                    DS_DUMMY: begin
                        next_s.byte_cnt = s.byte_cnt + 2'h1;
                        if (s.byte_cnt == 2'h2) begin
                            next_s.state  = DS_READ_OUT;
                            next_s.obuf   = s.sector_protect_table[7:0];
                            next_s.rd_idx = 3'h1;
                            next_s.obit   = 3'h0;
                        end
                    end
                    DS_READ_OUT, DS_IGNORE: begin
                    end
                endcase
            end
        end else if (sck_fall && s.state == DS_READ_OUT) begin
            // table bytes out on falling edges
            next_s.miso    = s.obuf[7];
            next_s.miso_oe = 1'b1;
            next_s.obuf    = {s.obuf[6:0], 1'b0};
            next_s.obit    = s.obit + 3'h1;
            if (s.obit == 3'h7) begin
                // past byte 7 the index wraps, byte 0 comes out again
                next_s.obuf   = s.sector_protect_table[{s.rd_idx, 3'b000} +: 8];
                next_s.rd_idx = s.rd_idx + 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s <= '0;
            s.cs_sync <= 3'h7;
        end else if (clk_en_i) begin
            s <= next_s;
        end
    end

    assign table_o     = s.sector_protect_table;
    assign busy_o      = (s.cycle != CY_NONE);
    assign blocked_o   = s.blocked;
    assign refused_o   = s.refused;
    assign buf1_we_o   = s.buf1_we;
    assign buf1_addr_o = s.buf1_addr;
    assign buf1_data_o = s.buf1_data;
    assign link.miso    = s.miso;
    assign link.miso_oe = s.miso_oe;

endmodule

// [logic/spr_host.sv]
// Host end: APB-controlled sequencer that issues table erase, program and read frames
`include "spr_params.svh"
module spr_host
    import spr_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        clk_en_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    spi_link_if.host         link
);

    host_regs_t s;
    host_regs_t next_s;

    function automatic logic [7:0] tx_byte(host_cmd_t c, logic [3:0] idx, logic [63:0] d);
        logic [7:0] b;
        b = 8'h00;
        if (c == HC_READ) begin
            b = (idx == 4'h0) ? `OP_READ : 8'h00;
        end else begin
            unique case (idx)
                4'h0: b = `OP_PREFIX0;
                4'h1: b = `OP_PREFIX1;
                4'h2: b = `OP_PREFIX2;
                4'h3: b = (c == HC_ERASE) ? `OP_ERASE : `OP_PROGRAM;
                // frame byte 4 carries table byte 0
                default: b = d[{~idx[2], idx[1:0], 3'b000} +: 8];
            endcase
        end
        return b;
    endfunction

    function automatic logic bytes_legal(logic [63:0] d);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 8; i++) begin
            ok = ok & (d[i * 8 +: 8] == `BYTE_CLEAR || d[i * 8 +: 8] == `BYTE_ERASED);
        end
        return ok;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // APB read side, zero wait states

    always_comb begin
        prdata_o  = 32'h0000_0000;
        pslverr_o = 1'b0;
        unique case (paddr_i)
            `REG_CTRL:   prdata_o = {30'h0, s.cmd};
            `REG_STATUS: prdata_o = {17'h0, s.wear, s.state != HS_IDLE};
            `REG_DATA0:  prdata_o = s.data[31:0];
            `REG_DATA1:  prdata_o = s.data[63:32];
            default:     pslverr_o = psel_i;
        endcase
    end
    assign pready_o = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        logic       wr;
        logic       go;
        logic       half_done;
        logic [3:0] last;
        logic [7:0] rbyte;
        logic [7:0] nt;
        host_cmd_t  c;
        wr        = psel_i & penable_i & pwrite_i;
        c         = host_cmd_t'(pwdata_i[1:0]);
        go        = 1'b0;
        half_done = (s.div == `SCK_HALF - 3'h1);
        last      = (s.cmd == HC_ERASE) ? 4'h3 : 4'hB;
        rbyte     = {s.rx[6:0], s.miso_sync[1]};
        nt        = 8'h00;

        next_s = s;
        next_s.miso_sync = {s.miso_sync[0], link.miso};
        next_s.div = half_done ? 3'h0 : s.div + 3'h1;

        unique case (s.state)
            HS_IDLE: begin
                next_s.div = 3'h0;
                if (wr && paddr_i == `REG_DATA0) next_s.data[31:0] = pwdata_i;
                if (wr && paddr_i == `REG_DATA1) next_s.data[63:32] = pwdata_i;
                if (wr && paddr_i == `REG_CTRL) begin
                    unique case (c)
                        HC_NONE: go = 1'b0;
                        HC_ERASE: go = (s.wear != `WEAR_LIMIT);
                        // erase must precede program; only 00H/FFH
                        HC_PROGRAM: go = s.erased && bytes_legal(s.data) && (s.wear != `WEAR_LIMIT);
                        HC_READ: go = 1'b1;
                    endcase
                end
                if (go) begin
                    // select low, first bit valid before first rise
                    nt = tx_byte(c, 4'h0, s.data);
                    next_s.cmd      = c;
                    next_s.state    = HS_LOW;
                    next_s.cs_n     = 1'b0;
                    next_s.byte_idx = 4'h0;
                    next_s.bit_idx  = 3'h0;
                    next_s.tx       = nt;
                    next_s.mosi     = nt[7];
                    if (c == HC_ERASE) begin
                        next_s.erased = 1'b1;
                        next_s.wear   = s.wear + 14'h0001;
                    end
                    if (c == HC_PROGRAM) begin
                        next_s.erased = 1'b0;
                    end
                end
            end
            HS_LOW: begin
                if (half_done) begin
                    next_s.sck   = 1'b1;
                    next_s.state = HS_HIGH;
                end
            end
            HS_HIGH: begin
                if (half_done) begin
                    next_s.sck     = 1'b0;
                    next_s.rx      = rbyte;
                    next_s.state   = HS_LOW;
                    next_s.bit_idx = s.bit_idx + 3'h1;
                    next_s.tx      = {s.tx[6:0], 1'b0};
                    next_s.mosi    = s.tx[6];
                    if (s.bit_idx == 3'h7) begin
                        if (s.cmd == HC_READ && s.byte_idx >= 4'h4) begin
                            // frame byte 4 is table byte 0
                            next_s.data[{~s.byte_idx[2], s.byte_idx[1:0], 3'b000} +: 8] = rbyte;
                        end
                        // exactly eight data bytes for program and read; an erase frame ends after its four opcode bytes
                        if (s.byte_idx == last) begin
                            next_s.state = HS_HOLD;
                            next_s.mosi  = 1'b0;
                        end else begin
                            nt = tx_byte(s.cmd, s.byte_idx + 4'h1, s.data);
                            next_s.byte_idx = s.byte_idx + 4'h1;
                            next_s.tx       = nt;
                            next_s.mosi     = nt[7];
                        end
                    end
                end
            end
            HS_HOLD: begin
                if (half_done) begin
                    // deselect starts the timed cycle; ends a read
                    next_s.cs_n  = 1'b1;
                    next_s.state = HS_GAP;
                end
            end
            HS_GAP: begin
                if (half_done) begin
                    next_s.state = HS_IDLE;
                end
            end
            default: begin
                next_s.state = HS_IDLE;
                next_s.cs_n  = 1'b1;
                next_s.sck   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            s <= '0;
            s.cs_n <= 1'b1;
        end else if (clk_en_i) begin
            s <= next_s;
        end
    end

    assign link.cs_n = s.cs_n;
    assign link.sck  = s.sck;
    assign link.mosi = s.mosi;

endmodule

// [logic/spr_params.svh]
// Constants for the sector protection table link: opcodes, sizes, timing, host register map
//
// Contract
// - Eight table bytes, one per sector
// - Selection applies under command or pin protection
// - Sector 0 split: bits 7:6 and 5:4
// - Table bytes read 00H when delivered
// - Table erased before it is reprogrammed
// - Erase opcode 3D 2A 7F CF, starts on deselect
// - Busy reported during table erase
// - Erase sets FFH, all sectors protected
// - Erase accepted with protection on or off
// - Program opcode 3D 2A 7F FC, eight bytes
// - Data bytes stored sector 0 upward
// - Deselect after data starts timed program, busy
// - Host sends all eight data bytes
// - Ninth byte wraps to location 0
// - Host writes only 00H or FFH
// - Program accepted with protection on or off
// - Program overwrites SRAM buffer 1
// - Read: 32H, three dummies, bytes 0..7 out
// - Bytes past the eighth are undefined
// - Deselect ends read, output released
// - Host limits table rewrites to 10,000
// - Marked sectors blocked only while protection enabled
// - Write-protect input blocks table erase/program
`ifndef SPR_PARAMS_SVH
`define SPR_PARAMS_SVH

`define OP_PREFIX0      8'h3D
`define OP_PREFIX1      8'h2A
`define OP_PREFIX2      8'h7F
`define OP_ERASE        8'hCF
`define OP_PROGRAM      8'hFC
`define OP_READ         8'h32
`define BYTE_ERASED     8'hFF
`define BYTE_CLEAR      8'h00
`define PAIR_SET        2'h3

`define CORE_MHZ        25
`define ERASE_TIME_US   20
`define PROG_TIME_US    40
`define ERASE_CYC       (`ERASE_TIME_US * `CORE_MHZ)
`define PROG_CYC        (`PROG_TIME_US * `CORE_MHZ)
`define SCK_HALF        3'h4
`define WEAR_LIMIT      14'h2710

`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_DATA0       8'h08
`define REG_DATA1       8'h0C

`endif

// [logic/spr_pkg.sv]
// Types shared by both ends of the sector protection table link
package spr_pkg;
`include "spr_params.svh"

    typedef enum logic [2:0] {
        DS_OPCODE    = 3'b000,
        DS_PROG_DATA = 3'b001,
        DS_DUMMY     = 3'b010,
        DS_READ_OUT  = 3'b011,
        DS_IGNORE    = 3'b100
    } dev_state_t;

    typedef enum logic [1:0] {
        CY_NONE    = 2'b00,
        CY_ERASE   = 2'b01,
        CY_PROGRAM = 2'b10
    } cycle_t;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_LOW  = 3'b001,
        HS_HIGH = 3'b010,
        HS_HOLD = 3'b011,
        HS_GAP  = 3'b100
    } host_state_t;

    typedef enum logic [1:0] {
        HC_NONE    = 2'b00,
        HC_ERASE   = 2'b01,
        HC_PROGRAM = 2'b10,
        HC_READ    = 2'b11
    } host_cmd_t;

    typedef struct packed {
        logic [2:0]  cs_sync;
        logic [2:0]  sck_sync;
        logic [1:0]  mosi_sync;
        dev_state_t  state;
        logic [2:0]  bit_cnt;
        logic [1:0]  byte_cnt;
        logic [7:0]  shreg;
        logic        seq_ok;
        logic        erase_req;
        logic [2:0]  wr_ptr;
        logic        any_data;
        logic [63:0] sector_protect_table;
        logic [63:0] stage;
        logic [7:0]  obuf;
        logic [2:0]  rd_idx;
        logic [2:0]  obit;
        logic        miso;
        logic        miso_oe;
        cycle_t      cycle;
        logic [11:0] timer;
        logic        buf1_we;
        logic [2:0]  buf1_addr;
        logic [7:0]  buf1_data;
        logic [8:0]  blocked;
        logic        refused;
    } dev_regs_t;

    typedef struct packed {
        host_state_t state;
        host_cmd_t   cmd;
        logic [2:0]  div;
        logic [2:0]  bit_idx;
        logic [3:0]  byte_idx;
        logic [7:0]  tx;
        logic [7:0]  rx;
        logic [63:0] data;
        logic [1:0]  miso_sync;
        logic        sck;
        logic        cs_n;
        logic        mosi;
        logic        erased;
        logic [13:0] wear;
    } host_regs_t;
endpackage

// [testbench/sector_protect_register_ctrl_test.sv]
// Bench: APB host end and device end joined by the serial link
`include "spr_params.svh"
module sector_protect_register_ctrl_test
    import spr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk_i = 1'b0;
    logic        nrst_i = 1'b0;
    logic        psel_i = 1'b0;
    logic        penable_i = 1'b0;
    logic        pwrite_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic        wp_i = 1'b0;
    logic        prot_enable_i = 1'b0;
    logic [31:0] prdata_o, r;
    logic        pready_o, pslverr_o, busy_o, refused_o, buf1_we_o;
    logic [63:0] table_o, t;
    logic [8:0]  blocked_o;
    logic [2:0]  buf1_addr_o;
    logic [7:0]  buf1_data_o;
    logic [33:0] rdq[$];
    logic [10:0] bq[$];
    int          mismatches = 0;
    int          n_compared = 0;
    int          nref = 0;

    always #20 core_clk_i = ~core_clk_i;
    spi_link_if link();
    spr_host i_spr_host (.core_clk_i, .nrst_i, .clk_en_i(1'b1), .psel_i, .penable_i, .pwrite_i, .paddr_i,
        .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link);
    spr_device i_spr_device (.core_clk_i, .nrst_i, .clk_en_i(1'b1), .link, .wp_i, .prot_enable_i, .busy_o,
        .table_o, .blocked_o, .refused_o, .buf1_we_o, .buf1_addr_o, .buf1_data_o);
    spr_checker i_spr_checker (.core_clk_i, .nrst_i, .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
        .miso(link.miso), .miso_oe(link.miso_oe), .wp_i, .prot_enable_i, .busy_o, .refused_o, .table_o, .blocked_o);

    ////////////////////////////////////////////////////////////////
    task automatic test_done();
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // Top bit of a read note marks a poll whose data is not compared
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
        @(posedge core_clk_i);
        if (!w) begin
            rdq.push_back(e);
        end
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        @(posedge core_clk_i);
        while (pready_o !== 1'b1) @(posedge core_clk_i);
        r = prdata_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic cmd(input logic [31:0] c);
        apb(1'b1, `REG_CTRL, c, 34'h0);
        r = 32'h1;
        while (r[0] !== 1'b0) apb(1'b0, `REG_STATUS, 32'h0, {1'b1, 33'h0});
        repeat (8) @(posedge core_clk_i);
        while (busy_o !== 1'b0) @(posedge core_clk_i);
    endtask

    task automatic read_table(input logic [63:0] e);
        cmd(32'h3);
        apb(1'b0, `REG_DATA0, 32'h0, {2'b00, e[31:0]});
        apb(1'b0, `REG_DATA1, 32'h0, {2'b00, e[63:32]});
    endtask

    always @(posedge core_clk_i) begin
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1 && !rdq[0][33]) begin
            check("prdata", 64'({pslverr_o, prdata_o}), 64'(rdq[0][32:0]));
        end
        if (psel_i && penable_i && !pwrite_i && pready_o === 1'b1) begin
            void'(rdq.pop_front());
        end
        if (buf1_we_o === 1'b1) begin
            check("buffer one write", 64'({buf1_addr_o, buf1_data_o}), 64'(bq.pop_front()));
        end
        if (refused_o === 1'b1) begin
            nref++;
        end
    end

    initial begin
        repeat (60000) @(posedge core_clk_i);
        mismatches++;
        test_done();
    end

    initial begin
        r = $urandom(32'hD54A);
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        apb(1'b0, `REG_STATUS, 32'h0, 34'h0);
        read_table(64'h0);
        apb(1'b0, 8'h10, 32'h0, {2'b01, 32'h0});
        wp_i <= 1'b1;
        cmd(32'h1);
        check("refusals", 64'(nref), 64'h1);
        read_table(64'h0);
        wp_i <= 1'b0;
        // Erase then program, once with protection off and once on
        for (int i = 0; i < 2; i++) begin
            prot_enable_i <= 1'(i);
            cmd(32'h1);
            read_table({64{1'b1}});
            for (int k = 0; k < 8; k++) begin
                t[8 * k +: 8] = $urandom_range(1) ? 8'hFF : 8'h00;
                bq.push_back({3'(k), t[8 * k +: 8]});
            end
            apb(1'b1, `REG_DATA0, t[31:0], 34'h0);
            apb(1'b1, `REG_DATA1, t[63:32], 34'h0);
            cmd(32'h2);
            read_table(t);
        end
        apb(1'b1, `REG_DATA0, ~t[31:0], 34'h0);
        cmd(32'h2);
        read_table(t);
        check("buffer notes left", 64'(bq.size()), 64'h0);
        test_done();
    end
endmodule

// [testbench/spr_checker.sv]
// Concurrent checks on the serial link and the device status outputs
`include "spr_params.svh"
module spr_checker
    import spr_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic        cs_n,
    input wire logic        sck,
    input wire logic        mosi,
    input wire logic        miso,
    input wire logic        miso_oe,
    input wire logic        wp_i,
    input wire logic        prot_enable_i,
    input wire logic        busy_o,
    input wire logic        refused_o,
    input wire logic [63:0] table_o,
    input wire logic [8:0]  blocked_o
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ERASE_HI = `ERASE_CYC + 2;
    localparam int PROG_LO  = `PROG_CYC - 2;
    localparam int PROG_HI  = `PROG_CYC + 2;
    logic [11:0] busy_len;
    logic [8:0]  exp_blk;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    // Length of the current timed cycle, cleared whenever idle
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i || !busy_o) begin
            busy_len <= 12'h000;
        end else begin
            busy_len <= busy_len + 12'h001;
        end
    end

    always_comb begin
        exp_blk[0] = table_o[7:6] == 2'h3;
        exp_blk[1] = table_o[5:4] == 2'h3;
        for (int k = 1; k < 8; k++) begin
            exp_blk[k + 1] = table_o[8 * k +: 8] == 8'hFF;
        end
        if (!(prot_enable_i || wp_i)) begin
            exp_blk = 9'h000;
        end
    end

    ////////////////////////////////////////////////////////////////
    sequence s_end;
        !cs_n ##1 cs_n;
    endsequence
    property p_gap; s_end |=> cs_n [*3]; endproperty
    a_gap: assert property (p_gap) else $error("deselect gap too short");
    property p_sck_idle; cs_n [*2] |-> !sck; endproperty
    a_sck_idle: assert property (p_sck_idle) else $error("clock not idle low");
    property p_mosi; !cs_n && $changed(mosi) |-> !sck; endproperty
    a_mosi: assert property (p_mosi) else $error("data moved with clock high");
    property p_oe_off; cs_n [*6] |-> !miso_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
    property p_busy_cs; $rose(busy_o) |-> cs_n; endproperty
    a_busy_cs: assert property (p_busy_cs) else $error("busy before deselect");
    property p_busy_len; $fell(busy_o) |-> busy_len inside {[498:ERASE_HI], [PROG_LO:PROG_HI]}; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_erase_ff; $fell(busy_o) && busy_len <= ERASE_HI |-> ##[0:1] table_o == {64{1'b1}}; endproperty
    a_erase_ff: assert property (p_erase_ff) else $error("erase left bytes clear");
    property p_wp; wp_i [*8] |-> !$rose(busy_o); endproperty
    a_wp: assert property (p_wp) else $error("table cycle under write protect");
    property p_refused; refused_o |=> !refused_o; endproperty
    a_refused: assert property (p_refused) else $error("refusal pulse too long");
    property p_blk; ($stable(table_o) && $stable(prot_enable_i) && $stable(wp_i)) [*3] |-> blocked_o == exp_blk;
    endproperty
    a_blk: assert property (p_blk) else $error("blocked map wrong");
endmodule
